/* File: rtl/lpms_params.svh */
// Constants for the low-power mode and boost sequencer.
// Assumes a 20 MHz ref_clk; included by the design modules, not by the package.
`ifndef LPMS_PARAMS_SVH
`define LPMS_PARAMS_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define LPMS_CLK_HZ          20000000
`define LPMS_SLEEP_RESUME_NS 15000
`define LPMS_SLEEP_RESUME_CYC ((`LPMS_SLEEP_RESUME_NS * (`LPMS_CLK_HZ / 1000000) + 999) / 1000)
`define LPMS_HIB_RESUME_MAX_NS 100000
`define LPMS_HIB_RESUME_MAX_CYC ((`LPMS_HIB_RESUME_MAX_NS * (`LPMS_CLK_HZ / 1000000)) / 1000)
`define LPMS_HIB_RESUME_CYC  64
`define LPMS_REFRESH_CYC     2000
`define LPMS_REFRESH_LEN     16

// ---------------------------------------------------------------
// Boost and wake source codes
// ---------------------------------------------------------------
`define LPMS_VSEL_W          6
`define LPMS_VSEL_MAX        6'h20
`define LPMS_VSEL_RESET      6'h00
`define LPMS_BOOST_FSW_HZ    400000
`define LPMS_SRC_W           4
`define LPMS_SRC_PIN         0

`endif

/* File: rtl/lpms_pkg.sv */
// Types for the low-power mode and boost sequencer.
// Assumes nothing beyond the constants header.
`default_nettype none
package lpms_pkg;
    // -----------------------------------------------------------
    // Modes
    // -----------------------------------------------------------
    typedef enum logic [2:0] {
        LPMS_ACTIVE     = 3'b000,
        LPMS_ALT_ACTIVE = 3'b001,
        LPMS_SLEEP      = 3'b010,
        LPMS_SLEEP_WAKE = 3'b011,
        LPMS_HIBERNATE  = 3'b100,
        LPMS_HIB_WAKE   = 3'b101
    } lpms_mode_type;

    typedef enum logic [1:0] {
        LPMS_REQ_ACTIVE = 2'b00,
        LPMS_REQ_ALT    = 2'b01,
        LPMS_REQ_SLEEP  = 2'b10,
        LPMS_REQ_HIB    = 2'b11
    } lpms_req_type;
endpackage : lpms_pkg
`default_nettype wire

/* File: rtl/lpms_wake_mux.sv */
// Combines wakeup sources, interrupts under their enables and resets ungated; the sequencer picks the output per power mode.
// Assumes all inputs synchronous to ref_clk.
`default_nettype none
`include "lpms_params.svh"
module lpms_wake_mux
    import lpms_pkg::*;
#(
    parameter int SRC_W = `LPMS_SRC_W
) (
    input  wire logic [SRC_W-1:0] irq_src,
    input  wire logic [SRC_W-1:0] irq_enable,
    input  wire logic             pin_irq,
    input  wire logic             pin_irq_enable,
    input  wire logic             external_reset_pin_n,
    input  wire logic             watchdog_timer_reset,
    input  wire logic             precise_low_voltage_reset,
    output logic                  wake_any,
    output logic                  wake_pin
);
    logic [SRC_W-1:0] gated;

    // ---------------------------------------------------------------
    // Per-source gating
    // ---------------------------------------------------------------
    for (genvar i = 0; i < SRC_W; i++) begin : g_src
        assign gated[i] = irq_src[i] & irq_enable[i]; // R8
    end

    // Pin interrupt, or the reset pin in the sequencer, can wake hibernate
    assign wake_pin = pin_irq & pin_irq_enable; // R4
    // Any enabled interrupt or reset source
    assign wake_any = (|gated) | wake_pin | ~external_reset_pin_n
                      | watchdog_timer_reset | precise_low_voltage_reset; // R7 R10
endmodule : lpms_wake_mux
`default_nettype wire

/* File: rtl/lpms_counter.sv */
// Down counter used for resume intervals and boost refresh timing.
// Assumes a synchronous load and a shared clock enable.
`default_nettype none
`include "lpms_params.svh"
module lpms_counter #(
    parameter int W = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic         clk_en,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              zero
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    initial begin
        if (W < 2) $error("lpms_counter width too small");
    end

    // ---------------------------------------------------------------
    // Next count
    // ---------------------------------------------------------------
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_val;
        end else if (count != '0) begin
            next_count = count - W'(1);
        end
    end

    // Register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (clk_en) begin
            count <= next_count;
        end
    end

    assign zero = (count == '0);
endmodule : lpms_counter
`default_nettype wire

/* File: rtl/lpms_sequencer.sv */
// Low-power mode and boost sequencer: mode FSM, wake handling, boost mode.
// Assumes firmware drives mode requests as one-cycle pulses on ref_clk.
`default_nettype none
`include "lpms_params.svh"
// Behaviour
// [R1] Sleep exit waits fixed 15 us resume
// [R2] Hibernate retains config and SRAM, rest off
// [R3] Hibernate holds GPIO outputs and pin interrupts
// [R4] Only pin interrupt leaves hibernate; code also leaves it on external_reset_pin_n low
// [R5] Hibernate resume completes under 100 us
// [R6] Inputs toggle below 10 kHz in hibernate
// [R7] Any enabled wake event returns to active
// [R8] Peripheral, supervisor, timewheel, pin interrupts wake
// [R9] Timewheel raises periodic wake interrupts
// [R10] Reset pin, watchdog, low-voltage reset wake
// [R11] Boost voltage code 1.8-5.0 V, 100 mV
// [R12] Boost switches at fixed internal 400 kHz
// [R13] Boost has active and standby modes
// [R14] Chip active means boost active
// [R15] Sleep standby boost needs periodic refresh wake
// [R16] Hibernate boost only active, discouraged
// [R17] Boost supply without fast option uses 12 MHz
// [R18] Boot active; wake re-enables processor
// [R19] Pending wake aborts low-power entry
module lpms_sequencer
    import lpms_pkg::*;
#(
    parameter int SRC_W       = `LPMS_SRC_W,
    parameter int TW_PERIOD   = 20000,
    parameter int REFRESH_CYC = `LPMS_REFRESH_CYC
) (
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    input  wire logic                   clk_en,
    input  wire logic                   mode_req_valid,
    input  wire lpms_req_type           mode_req,
    input  wire logic                   cpu_template_en,
    input  wire logic [SRC_W-1:0]       irq_src,
    input  wire logic [SRC_W-1:0]       irq_enable,
    input  wire logic                   pin_irq,
    input  wire logic                   pin_irq_enable,
    input  wire logic                   timewheel_enable,
    input  wire logic                   external_reset_pin_n,
    input  wire logic                   watchdog_timer_reset,
    input  wire logic                   precise_low_voltage_reset,
    input  wire logic                   boost_sleep_standby,
    input  wire logic                   boost_hib_active,
    input  wire logic [`LPMS_VSEL_W-1:0] boost_vsel_in,
    input  wire logic                   boost_vsel_load,
    input  wire logic                   boost_supplies_chip,
    input  wire logic                   fast_startup_clock_option,
    input  wire logic                   startup_phase,
    input  wire logic [7:0]             gpio_out_in,
    output lpms_mode_type               mode,
    output logic                        cpu_enable,
    output logic                        retain_enable,
    output logic                        func_enable,
    output logic [7:0]                  gpio_out,
    output logic                        pin_irq_cfg_hold,
    output logic                        boost_active,
    output logic [`LPMS_VSEL_W-1:0]     boost_vsel,
    output logic                        boost_osc_internal,
    output logic                        main_internal_oscillator_12mhz,
    output logic                        timewheel_irq,
    output logic                        entry_aborted
);
    localparam int SLP_CYC = `LPMS_SLEEP_RESUME_CYC;
    localparam int HIB_CYC = `LPMS_HIB_RESUME_CYC;
    localparam int HIB_MAX = `LPMS_HIB_RESUME_MAX_CYC;

    initial begin
        if (HIB_CYC >= HIB_MAX) $error("hibernate resume too long");
        if (SRC_W < 1 || TW_PERIOD < 2 || REFRESH_CYC < 2) $error("bad parameter");
    end

    lpms_mode_type               next_mode;
    logic                        next_cpu_enable;
    logic [7:0]                  next_gpio_out;
    logic [`LPMS_VSEL_W-1:0]     next_boost_vsel;
    logic                        next_boost_active;
    logic                        next_entry_aborted;
    logic [15:0]                 tw_count;
    logic [15:0]                 next_tw_count;
    logic                        next_timewheel_irq;
    logic                        wake_any;
    logic                        wake_pin;
    logic                        res_load;
    logic [15:0]                 res_val;
    logic                        res_zero;
    logic                        ref_load;
    logic                        ref_zero;
    logic                        refreshing;
    logic [4:0]                  ref_len;
    logic [4:0]                  next_ref_len;
    logic                        low_power;

    // ---------------------------------------------------------------
    // Submodules
    // ---------------------------------------------------------------
    lpms_wake_mux #(.SRC_W(SRC_W + 1)) u_wake (
        .irq_src                   ({timewheel_irq, irq_src}),
        .irq_enable                ({timewheel_enable, irq_enable}),
        .pin_irq                   (pin_irq),
        .pin_irq_enable            (pin_irq_enable),
        .external_reset_pin_n      (external_reset_pin_n),
        .watchdog_timer_reset      (watchdog_timer_reset),
        .precise_low_voltage_reset (precise_low_voltage_reset),
        .wake_any                  (wake_any),
        .wake_pin                  (wake_pin)
    );

    lpms_counter #(.W(16)) u_resume (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .load     (res_load),
        .load_val (res_val),
        .zero     (res_zero)
    );

    lpms_counter #(.W(16)) u_refresh (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .load     (ref_load),
        .load_val (16'(REFRESH_CYC)),
        .zero     (ref_zero)
    );

    assign low_power = (mode == LPMS_SLEEP) || (mode == LPMS_HIBERNATE);

    // ---------------------------------------------------------------
    // Mode state machine
    // ---------------------------------------------------------------
    always_comb begin
        next_mode          = mode;
        next_cpu_enable    = cpu_enable;
        next_entry_aborted = 1'b0;
        res_load           = 1'b0;
        res_val            = 16'(SLP_CYC);
        case (mode)
            LPMS_ACTIVE, LPMS_ALT_ACTIVE: begin
                if (mode_req_valid) begin
                    case (mode_req)
                        LPMS_REQ_ACTIVE: begin
                            next_mode       = LPMS_ACTIVE;
                            next_cpu_enable = cpu_template_en;
                        end
                        LPMS_REQ_ALT: begin
                            next_mode       = LPMS_ALT_ACTIVE;
                            next_cpu_enable = cpu_template_en;
                        end
                        LPMS_REQ_SLEEP: begin
                            if (wake_any) begin
                                next_entry_aborted = 1'b1; // R19
                            end else begin
                                next_mode = LPMS_SLEEP;
                            end
                        end
                        LPMS_REQ_HIB: begin
                            if (wake_pin || wake_any) begin
                                next_entry_aborted = 1'b1; // R19
                            end else begin
                                next_mode = LPMS_HIBERNATE;
                            end
                        end
                        default: next_mode = mode;
                    endcase
                end
            end
            LPMS_SLEEP: begin
                if (wake_any) begin
                    next_mode = LPMS_SLEEP_WAKE; // R7
                    res_load  = 1'b1;
                    res_val   = 16'(SLP_CYC - 1); // R1
                end
            end
            LPMS_SLEEP_WAKE: begin
                if (res_zero) begin
                    next_mode       = LPMS_ACTIVE; // R18
                    next_cpu_enable = 1'b1;
                end
            end
            LPMS_HIBERNATE: begin
                if (wake_pin || !external_reset_pin_n) begin
                    next_mode = LPMS_HIB_WAKE; // R4
                    res_load  = 1'b1;
                    res_val   = 16'(HIB_CYC - 1); // R5
                end
            end
            LPMS_HIB_WAKE: begin
                if (res_zero) begin
                    next_mode       = LPMS_ACTIVE; // R18
                    next_cpu_enable = 1'b1;
                end
            end
            default: begin
                next_mode       = LPMS_ACTIVE;
                next_cpu_enable = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode          <= LPMS_ACTIVE; // R18
            cpu_enable    <= 1'b1;
            entry_aborted <= 1'b0;
        end else if (clk_en) begin
            mode          <= next_mode;
            cpu_enable    <= next_cpu_enable;
            entry_aborted <= next_entry_aborted;
        end
    end

    // ---------------------------------------------------------------
    // Retention, GPIO hold and functional gating
    // ---------------------------------------------------------------
    assign retain_enable    = 1'b1; // R2
    assign func_enable      = !low_power; // R2
    assign pin_irq_cfg_hold = (mode == LPMS_HIBERNATE); // R3

    always_comb begin
        next_gpio_out = gpio_out;
        if (mode != LPMS_HIBERNATE) begin
            next_gpio_out = gpio_out_in;
        end
    end

    // GPIO level frozen in hibernate
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gpio_out <= 8'h00;
        end else if (clk_en) begin
            gpio_out <= next_gpio_out; // R3
        end
    end

    // ---------------------------------------------------------------
    // Central timewheel
    // ---------------------------------------------------------------
    always_comb begin
        next_tw_count      = tw_count + 16'h0001;
        next_timewheel_irq = 1'b0;
        if (tw_count >= 16'(TW_PERIOD - 1)) begin
            next_tw_count      = 16'h0000;
            next_timewheel_irq = 1'b1; // R9
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tw_count      <= 16'h0000;
            timewheel_irq <= 1'b0;
        end else if (clk_en) begin
            tw_count      <= next_tw_count;
            timewheel_irq <= next_timewheel_irq;
        end
    end

    // ---------------------------------------------------------------
    // Boost mode, refresh and voltage code
    // ---------------------------------------------------------------
    assign refreshing = (ref_len != 5'h00);
    assign ref_load   = (mode != LPMS_SLEEP) || !boost_sleep_standby || ref_zero;

    always_comb begin
        next_ref_len = refreshing ? ref_len - 5'h01 : 5'h00;
        if (mode == LPMS_SLEEP && boost_sleep_standby && ref_zero) begin
            next_ref_len = 5'(`LPMS_REFRESH_LEN); // R15
        end
        case (mode)
            LPMS_SLEEP:     next_boost_active = !boost_sleep_standby || refreshing; // R15
            LPMS_HIBERNATE: next_boost_active = boost_hib_active; // R16
            default:        next_boost_active = 1'b1; // R14
        endcase
        next_boost_vsel = boost_vsel;
        if (boost_vsel_load && boost_vsel_in <= `LPMS_VSEL_MAX) begin
            next_boost_vsel = boost_vsel_in; // R11
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            boost_active <= 1'b1; // R13
            boost_vsel   <= `LPMS_VSEL_RESET;
            ref_len      <= 5'h00;
        end else if (clk_en) begin
            boost_active <= next_boost_active; // R13
            boost_vsel   <= next_boost_vsel;
            ref_len      <= next_ref_len;
        end
    end

    assign boost_osc_internal = 1'b1; // R12
    assign main_internal_oscillator_12mhz =
        boost_supplies_chip && !fast_startup_clock_option && startup_phase; // R17

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // Cycles spent resuming from hibernate; bounds the resume time
    logic [15:0] hib_wait;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hib_wait <= 16'h0000;
        end else if (clk_en) begin
            hib_wait <= (mode == LPMS_HIB_WAKE) ? hib_wait + 16'h0001 : 16'h0000;
        end
    end

    chk_sleep_resume_len: assert property (@(posedge ref_clk) disable iff (!resetn) // R1
        (mode == LPMS_SLEEP && wake_any && clk_en) ##1 (mode == LPMS_SLEEP_WAKE)
        |-> (mode != LPMS_ACTIVE) [*8] or !clk_en [*1])
        else $error("sleep resume too short");
    chk_hib_exit_only: assert property (@(posedge ref_clk) disable iff (!resetn) // R4
        (mode == LPMS_HIBERNATE && !wake_pin && external_reset_pin_n && clk_en)
        |=> (mode == LPMS_HIBERNATE))
        else $error("hibernate left without pin");
    chk_hib_resume_max: assert property (@(posedge ref_clk) disable iff (!resetn) // R5
        hib_wait < 16'(HIB_MAX))
        else $error("hibernate resume too slow");
    chk_boost_active_run: assert property (@(posedge ref_clk) disable iff (!resetn) // R14
        $past(mode == LPMS_ACTIVE || mode == LPMS_ALT_ACTIVE) && $past(clk_en)
        |-> boost_active)
        else $error("boost not active in active");
    chk_gpio_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // R3
        (mode == LPMS_HIBERNATE) ##1 (mode == LPMS_HIBERNATE) |-> $stable(gpio_out))
        else $error("gpio changed in hibernate");
    chk_pending_abort: assert property (@(posedge ref_clk) disable iff (!resetn) // R19
        (mode == LPMS_ACTIVE && mode_req_valid && mode_req[1]
         && wake_any && clk_en) |=> (mode == LPMS_ACTIVE && entry_aborted))
        else $error("entry not aborted");
    chk_wake_cpu_on: assert property (@(posedge ref_clk) disable iff (!resetn) // R18
        (mode == LPMS_SLEEP_WAKE && res_zero && clk_en) |=> (mode == LPMS_ACTIVE && cpu_enable))
        else $error("cpu not re-enabled");
    chk_vsel_range: assert property (@(posedge ref_clk) disable iff (!resetn) // R11
        boost_vsel <= `LPMS_VSEL_MAX)
        else $error("boost code out of range");
endmodule : lpms_sequencer
`default_nettype wire

/* File: dv/lpms_far_model.sv */
// Far-side model: wake pin, general-purpose inputs, boost hibernate option.
// Assumes the sequencer's mode output and a single ref_clk domain.
`default_nettype none
module lpms_far_model
    import lpms_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          resetn,
    input  wire lpms_mode_type mode,
    input  wire logic          pin_req,
    output logic               pin_irq,
    output logic [7:0]         gpio_out_in,
    output logic               boost_hib_active
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------
    // Input activity
    // ----------------------------------------------------------
    logic [10:0] hib_cnt;
    // Boost stays off in hibernate, its active current is too high
    assign boost_hib_active = 1'b0;
    // Inputs count when awake; in hibernate one change per 2000 cycles
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hib_cnt     <= 11'h000;
            gpio_out_in <= 8'h00;
            pin_irq     <= 1'b0;
        end else begin
            pin_irq <= pin_req;
            if (mode == LPMS_HIBERNATE) begin
                hib_cnt <= (hib_cnt == 11'h7cf) ? 11'h000 : hib_cnt + 11'h001;
                if (hib_cnt == 11'h00a) begin
                    gpio_out_in <= ~gpio_out_in;
                end
            end else begin
                hib_cnt     <= 11'h000;
                gpio_out_in <= gpio_out_in + 8'h01;
            end
        end
    end
endmodule : lpms_far_model
`default_nettype wire

/* File: dv/lpms_sequencer_tb.sv */
// Self-checking bench for the low-power mode and boost sequencer.
// Assumes the package, design modules and far-side model compiled first.
`default_nettype none
module lpms_sequencer_tb
    import lpms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    logic          ref_clk = 1'b0;
    logic          resetn, clk_en, mode_req_valid, cpu_template_en;
    lpms_req_type  mode_req;
    logic [3:0]    irq_src, irq_enable;
    logic          pin_irq, pin_irq_enable, pin_req, timewheel_enable;
    logic          external_reset_pin_n, watchdog_timer_reset, precise_low_voltage_reset;
    logic          boost_sleep_standby, boost_hib_active, boost_vsel_load;
    logic [5:0]    boost_vsel_in, boost_vsel;
    logic          boost_supplies_chip, fast_startup_clock_option, startup_phase;
    logic [7:0]    gpio_out_in, gpio_out, g;
    lpms_mode_type mode;
    logic          cpu_enable, retain_enable, func_enable, pin_irq_cfg_hold;
    logic          boost_active, boost_osc_internal, main_internal_oscillator_12mhz;
    logic          timewheel_irq, entry_aborted, seen;
    int            n, n_tests = 0, n_mismatch = 0, cycles = 0;
    logic [5:0]    codes [3] = '{6'h05, 6'h20, 6'h21};
    logic [5:0]    kept [3]  = '{6'h05, 6'h20, 6'h20};

    always #25 ref_clk = ~ref_clk;

    lpms_sequencer #(.SRC_W(4), .TW_PERIOD(50), .REFRESH_CYC(40)) dut (.*);
    lpms_far_model far (.ref_clk(ref_clk), .resetn(resetn), .mode(mode), .pin_req(pin_req),
        .pin_irq(pin_irq), .gpio_out_in(gpio_out_in), .boost_hib_active(boost_hib_active));

    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // Waits on falling edges for a mode; n is the edges spent
    task automatic wait_mode(input lpms_mode_type m, input int lim, output int cnt);
        cnt = 1;
        @(negedge ref_clk);
        while (mode !== m && cnt < lim) begin
            cnt++;
            @(negedge ref_clk);
        end
    endtask : wait_mode

    task automatic req(input lpms_req_type r);
        @(posedge ref_clk);
        mode_req_valid <= 1'b1;
        mode_req       <= r;
        @(posedge ref_clk);
        mode_req_valid <= 1'b0;
    endtask : req

    // Raises one wake source, waits out the resume, then clears it
    task automatic wake(input int k, input lpms_mode_type wm, output int cnt);
        @(posedge ref_clk);
        case (k)
            0: irq_src <= 4'h2;
            1: watchdog_timer_reset <= 1'b1;
            2: precise_low_voltage_reset <= 1'b1;
            3: external_reset_pin_n <= 1'b0;
            4: timewheel_enable <= 1'b1;
            default: pin_req <= 1'b1;
        endcase
        wait_mode(wm, 90, cnt);
        wait_mode(LPMS_ACTIVE, 400, cnt);
        @(posedge ref_clk);
        irq_src                   <= 4'h0;
        watchdog_timer_reset      <= 1'b0;
        precise_low_voltage_reset <= 1'b0;
        external_reset_pin_n      <= 1'b1;
        timewheel_enable          <= 1'b0;
        pin_req                   <= 1'b0;
    endtask : wake

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 9000) begin
            n_mismatch++;
            results();
        end
    end

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        {resetn, clk_en, mode_req_valid, cpu_template_en, pin_req, timewheel_enable} = 6'h10;
        {watchdog_timer_reset, precise_low_voltage_reset, boost_sleep_standby} = 3'h0;
        {boost_vsel_load, boost_supplies_chip, fast_startup_clock_option, startup_phase} = 4'h0;
        external_reset_pin_n = 1'b1;
        mode_req             = LPMS_REQ_ACTIVE;
        irq_src              = 4'h0;
        irq_enable           = 4'hf;
        pin_irq_enable       = 1'b1;
        boost_vsel_in        = 6'h00;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        check(32'(mode), 32'(LPMS_ACTIVE));
        check(32'(cpu_enable), 32'h1);
        check(32'(boost_active), 32'h1);
        check(32'(boost_osc_internal), 32'h1);
        check(32'(boost_vsel), 32'h0);
        // Voltage codes: in range taken, one above the top refused
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            boost_vsel_in   <= codes[i];
            boost_vsel_load <= 1'b1;
            @(posedge ref_clk);
            boost_vsel_load <= 1'b0;
            @(negedge ref_clk);
            check(32'(boost_vsel), 32'(kept[i]));
        end
        // Startup clock for every supply, option and phase setting
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            {boost_supplies_chip, fast_startup_clock_option, startup_phase} <= 3'(i);
            @(negedge ref_clk);
            check(32'(main_internal_oscillator_12mhz), 32'(i == 5));
        end
        // Alternate active with processor off, then sleep and wake
        req(LPMS_REQ_ALT);
        wait_mode(LPMS_ALT_ACTIVE, 4, n);
        check(32'(cpu_enable), 32'h0);
        req(LPMS_REQ_SLEEP);
        wait_mode(LPMS_SLEEP, 4, n);
        check(32'(func_enable), 32'h0);
        check(32'(boost_active), 32'h1);
        wake(0, LPMS_SLEEP_WAKE, n);
        check(32'(n), 32'd300);
        check(32'(cpu_enable), 32'h1);
        // Every other wake source returns sleep to active
        for (int k = 1; k < 6; k++) begin
            req(LPMS_REQ_SLEEP);
            wait_mode(LPMS_SLEEP, 4, n);
            wake(k, LPMS_SLEEP_WAKE, n);
            check(32'(mode), 32'(LPMS_ACTIVE));
        end
        // Pending wake abandons entry
        @(posedge ref_clk);
        irq_src <= 4'h8;
        req(LPMS_REQ_HIB);
        seen = 1'b0;
        repeat (3) @(negedge ref_clk) seen |= entry_aborted;
        check(32'(seen), 32'h1);
        check(32'(mode), 32'(LPMS_ACTIVE));
        @(posedge ref_clk);
        irq_src <= 4'h0;
        // Standby boost in sleep gets periodic refresh
        boost_sleep_standby <= 1'b1;
        req(LPMS_REQ_SLEEP);
        wait_mode(LPMS_SLEEP, 4, n);
        @(negedge ref_clk);
        check(32'(boost_active), 32'h0);
        seen = 1'b0;
        repeat (60) @(negedge ref_clk) seen |= boost_active;
        check(32'(seen), 32'h1);
        wake(0, LPMS_SLEEP_WAKE, n);
        boost_sleep_standby <= 1'b0;
        @(negedge ref_clk);
        check(32'(boost_active), 32'h1);
        // Hibernate: retention, held outputs, interrupt and watchdog ignored, the pin wakes
        req(LPMS_REQ_HIB);
        wait_mode(LPMS_HIBERNATE, 4, n);
        check(32'(retain_enable), 32'h1);
        check(32'(pin_irq_cfg_hold), 32'h1);
        repeat (2) @(negedge ref_clk);
        g = gpio_out;
        @(posedge ref_clk);
        irq_src              <= 4'h1;
        watchdog_timer_reset <= 1'b1;
        repeat (30) @(negedge ref_clk);
        check(32'(mode), 32'(LPMS_HIBERNATE));
        check(32'(gpio_out), 32'(g));
        @(posedge ref_clk);
        irq_src              <= 4'h0;
        watchdog_timer_reset <= 1'b0;
        wake(5, LPMS_HIB_WAKE, n);
        check(32'(n), 32'd64);
        results();
    end
endmodule : lpms_sequencer_tb
`default_nettype wire
